// ===== rtl/status_event_and_queues.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Bit 0 high during sweep; fall marks done
// - Bit 1 high while output is on
// - Bit 3 high from setpoint change to 90%
// - Bits 5-8 report fan, temperatures, power fault
// - Bit 10 reports feedback correction error
// - Bit 11 reports amplifier oscillation
// - Bit 12 reports output overload
// - Per-bit filter, suffix n selects bit n-1
// - Rising mode sets event on 0-to-1
// - Falling mode sets event on 1-to-0
// - Both mode sets event on any change
// - Never mode keeps event bit at zero
// - Query answers wait in output queue
// - Output queue delivers oldest first
// - Message, deadlock, device clear, restart empty queue
// - Clear status leaves output queue alone
// - Status bit 4 shows output queue non-empty
// - Every error pushes a code; unknown gives 113
// - Error query returns oldest entry first
// - Overflow replaces last entry with code 350
// - Only clear status or restart empty errors
// - Status bit 2 shows error queue non-empty
// - Status bit 3 ORs enabled event bits

module status_event_and_queues
    import status_event_pkg::*;
#(
    parameter int OUT_DEPTH = OUT_Q_DEPTH,
    parameter int ERR_DEPTH = ERR_Q_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire fault_inputs_type faults,
    input wire logic cmd_valid,
    input wire cmd_type cmd,
    input wire logic new_message,
    input wire logic deadlock,
    input wire logic resp_push,
    input wire logic [WORD_W-1:0] resp_word,
    output logic resp_ready,
    input wire logic ctrl_read,
    output logic [WORD_W-1:0] out_word,
    output logic out_valid,
    output logic out_lost,
    input wire logic err_push,
    input wire logic [WORD_W-1:0] err_code,
    output logic err_ready,
    output logic [7:0] status_bits
);

    filter_mode_type [COND_W-1:0] filter_mode_ff;
    filter_mode_type [COND_W-1:0] nxt_filter_mode;
    logic [COND_W-1:0] cond_ff;
    logic [COND_W-1:0] nxt_cond;
    logic [COND_W-1:0] event_ff;
    logic [COND_W-1:0] nxt_event;
    logic [COND_W-1:0] enable_ff;
    logic [COND_W-1:0] nxt_enable;
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic settle_ff;
    logic nxt_settle;
    logic [COND_W-1:0] hits;
    logic [COND_W-1:0] never_mask;
    logic own_push;
    logic [WORD_W-1:0] own_word;
    logic own_err;
    logic [WORD_W-1:0] own_err_code;
    logic do_cls;
    logic do_dcl;
    logic ev_read;
    logic err_pop;
    logic out_q_push;
    logic out_flush;
    logic out_empty;
    logic err_q_push;
    logic err_empty;
    logic [WORD_W-1:0] err_head;

    // Suffix lies inside the addressable filter range
    function automatic logic suffix_ok(input logic [4:0] s);
        return (s >= SUFFIX_MIN) && (s <= SUFFIX_MAX);
    endfunction

    // Condition bit addressed by a filter suffix
    function automatic logic [3:0] suffix_bit(input logic [4:0] s);
        return 4'(s - SUFFIX_MIN);
    endfunction

    // Live condition word; setpoint change wins over reaching 90%
    always_comb
    begin
        nxt_settle = settle_ff;
        if (faults.setpoint_changed)
        begin
            nxt_settle = 1'b1;
        end
        else if (faults.output_at_90)
        begin
            nxt_settle = 1'b0;
        end
        nxt_cond = '0;
        nxt_cond[BIT_SWEEP] = faults.sweep_running;
        nxt_cond[BIT_OUTPUT] = faults.output_active;
        nxt_cond[BIT_SETTLE] = nxt_settle;
        nxt_cond[BIT_FAN] = faults.fan_stopped;
        nxt_cond[BIT_ITEMP] = faults.internal_over_temp;
        nxt_cond[BIT_ATEMP] = faults.amp_over_temp;
        nxt_cond[BIT_POWER] = faults.power_supply_fault;
        nxt_cond[BIT_FEEDBACK] = faults.feedback_error;
        nxt_cond[BIT_OSCILLATION] = faults.oscillation_error;
        nxt_cond[BIT_OVERLOAD] = faults.overload_detected;
    end

    // Command decode: register queries, filter and enable writes, clears
    always_comb
    begin
        nxt_filter_mode = filter_mode_ff;
        nxt_enable = enable_ff;
        own_push = 1'b0;
        own_word = '0;
        own_err = 1'b0;
        own_err_code = '0;
        do_cls = 1'b0;
        do_dcl = 1'b0;
        ev_read = 1'b0;
        err_pop = 1'b0;
        if (cmd_valid)
        begin
            case (cmd.op)
                op_cond_query:
                begin
                    own_push = 1'b1;
                    own_word = cond_ff;
                end
                op_event_query:
                begin
                    own_push = 1'b1;
                    own_word = event_ff;
                    ev_read = 1'b1;
                end
                op_filter_set:
                begin
                    if (suffix_ok(cmd.suffix))
                    begin
                        nxt_filter_mode[suffix_bit(cmd.suffix)] = cmd.mode;
                    end
                    else
                    begin
                        own_err = 1'b1;
                        own_err_code = ERR_SUFFIX_RANGE;
                    end
                end
                op_filter_query:
                begin
                    if (suffix_ok(cmd.suffix))
                    begin
                        own_push = 1'b1;
                        own_word = {14'h0000, filter_mode_ff[suffix_bit(cmd.suffix)]};
                    end
                    else
                    begin
                        own_err = 1'b1;
                        own_err_code = ERR_SUFFIX_RANGE;
                    end
                end
                op_enable_set:
                begin
                    nxt_enable = cmd.data;
                end
                op_enable_query:
                begin
                    own_push = 1'b1;
                    own_word = enable_ff;
                end
                op_error_query:
                begin
                    own_push = 1'b1;
                    own_word = err_empty ? ERR_NONE_CODE : err_head;
                    err_pop = !err_empty;
                end
                op_clear_status:
                begin
                    do_cls = 1'b1;
                end
                op_device_clear:
                begin
                    do_dcl = 1'b1;
                end
                default:
                begin
                    own_err = 1'b1;
                    own_err_code = ERR_UNDEFINED_HEADER;
                end
            endcase
        end
    end

    // Event latch: a new hit wins over a read or clear in the same cycle
    always_comb
    begin
        nxt_event = (ev_read || do_cls) ? '0 : event_ff;
        nxt_event = (nxt_event | hits) & ~never_mask & COND_USED_MASK;
    end

    // Summary bits for the status byte
    always_comb
    begin
        nxt_status = '0;
        nxt_status[SB_ERROR_AVAIL] = !err_empty;
        nxt_status[SB_EXT_SUMMARY] = |(event_ff & enable_ff);
        nxt_status[SB_MSG_AVAIL] = !out_empty;
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < COND_W; i++)
            begin
                filter_mode_ff[i] <= FILTER_RESET;
            end
            cond_ff <= '0;
            event_ff <= '0;
            enable_ff <= ENABLE_RESET;
            status_ff <= STATUS_RESET;
            settle_ff <= 1'b0;
        end
        else
        begin
            filter_mode_ff <= nxt_filter_mode;
            cond_ff <= nxt_cond;
            event_ff <= nxt_event;
            enable_ff <= nxt_enable;
            status_ff <= nxt_status;
            settle_ff <= nxt_settle;
        end
    end

    edge_filter_bank #(
        .WIDTH(COND_W)
    ) u_filter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .cond(cond_ff),
        .modes(filter_mode_ff),
        .hits(hits),
        .never_mask(never_mask)
    );

    // Own query answers take the output queue ahead of outside answers
    assign out_q_push = own_push || resp_push;
    assign out_flush = new_message || deadlock || do_dcl;
    assign resp_ready = !own_push;

    status_queue #(
        .WIDTH(WORD_W),
        .DEPTH(OUT_DEPTH),
        .OVERWRITE_LAST(1'b0),
        .LAST_MARK('0)
    ) u_out_queue (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .flush(out_flush),
        .push(out_q_push),
        .push_data(own_push ? own_word : resp_word),
        .pop(ctrl_read),
        .head(out_word),
        .empty(out_empty),
        .full(),
        .dropped(out_lost)
    );

    // Internal errors take the error queue ahead of outside errors
    assign err_q_push = own_err || err_push;
    assign err_ready = !own_err;

    status_queue #(
        .WIDTH(WORD_W),
        .DEPTH(ERR_DEPTH),
        .OVERWRITE_LAST(1'b1),
        .LAST_MARK(ERR_OVERFLOW_CODE)
    ) u_err_queue (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .flush(do_cls),
        .push(err_q_push),
        .push_data(own_err ? own_err_code : err_code),
        .pop(err_pop),
        .head(err_head),
        .empty(err_empty),
        .full(),
        .dropped()
    );

    assign out_valid = !out_empty;
    assign status_bits = status_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_sweep_end;
        cond_ff[BIT_SWEEP] ##1 (!cond_ff[BIT_SWEEP] && filter_mode_ff[BIT_SWEEP] == filt_fall);
    endsequence

    a_sweep_end_event: assert property (s_sweep_end |=> event_ff[BIT_SWEEP])
        else $error("sweep end not latched");

    a_output_on_bit: assert property (faults.output_active |=> cond_ff[BIT_OUTPUT])
        else $error("output bit not set");

    a_settle_start: assert property (faults.setpoint_changed |=> cond_ff[BIT_SETTLE])
        else $error("settling bit not set");

    a_settle_done: assert property (
        (faults.output_at_90 && !faults.setpoint_changed) |=> !cond_ff[BIT_SETTLE])
        else $error("settling bit not cleared");

    a_fault_bits: assert property (1'b1 |=> cond_ff[BIT_POWER:BIT_FAN] ==
        $past({faults.power_supply_fault, faults.amp_over_temp,
        faults.internal_over_temp, faults.fan_stopped}))
        else $error("fault bits wrong");

    a_error_flags: assert property (1'b1 |=> cond_ff[BIT_OVERLOAD:BIT_FEEDBACK] ==
        $past({faults.overload_detected, faults.oscillation_error, faults.feedback_error}))
        else $error("error flags wrong");

    a_rise_event: assert property (
        (filter_mode_ff[BIT_OUTPUT] == filt_rise && $rose(cond_ff[BIT_OUTPUT]))
        |=> event_ff[BIT_OUTPUT])
        else $error("rising edge not latched");

    a_both_event: assert property (
        (filter_mode_ff[BIT_OUTPUT] == filt_both && $changed(cond_ff[BIT_OUTPUT]))
        |=> event_ff[BIT_OUTPUT])
        else $error("change not latched");

    a_never_zero: assert property (
        filter_mode_ff[BIT_OUTPUT] == filt_never |=> !event_ff[BIT_OUTPUT])
        else $error("never mode event set");

    a_unused_zero: assert property (((cond_ff | event_ff) & ~COND_USED_MASK) == 16'h0000)
        else $error("unused bit set");

    a_msg_avail: assert property (
        (out_q_push && out_empty && !out_flush) |-> ##2 status_bits[SB_MSG_AVAIL])
        else $error("message available missing");

    a_out_flush: assert property (
        (out_flush && !out_q_push) |-> ##2 !status_bits[SB_MSG_AVAIL])
        else $error("output queue not emptied");

    a_cls_keeps_out: assert property (
        (do_cls && !out_flush && !ctrl_read && !out_empty) |=> !out_empty)
        else $error("clear status hit output queue");

    a_err_avail: assert property (err_q_push |-> ##2 status_bits[SB_ERROR_AVAIL])
        else $error("error available missing");

    a_err_kept: assert property (
        (!do_cls && !err_pop && !err_empty) |=> !err_empty)
        else $error("error queue lost entries");

    a_event_summary: assert property (
        (|(hits & enable_ff & ~never_mask & COND_USED_MASK) &&
        !(cmd_valid && cmd.op == op_enable_set)) |-> ##2 status_bits[SB_EXT_SUMMARY])
        else $error("event summary missing");

endmodule // status_event_and_queues

`default_nettype wire

// ===== shared/status_event_pkg.sv
package status_event_pkg;

    // Condition word layout
    localparam int COND_W = 16;
    localparam int BIT_SWEEP = 0;
    localparam int BIT_OUTPUT = 1;
    localparam int BIT_SETTLE = 3;
    localparam int BIT_FAN = 5;
    localparam int BIT_ITEMP = 6;
    localparam int BIT_ATEMP = 7;
    localparam int BIT_POWER = 8;
    localparam int BIT_FEEDBACK = 10;
    localparam int BIT_OSCILLATION = 11;
    localparam int BIT_OVERLOAD = 12;
    localparam logic [15:0] COND_USED_MASK = 16'h1deb;

    // Summary bit positions in the status byte
    localparam int SB_ERROR_AVAIL = 2;
    localparam int SB_EXT_SUMMARY = 3;
    localparam int SB_MSG_AVAIL = 4;

    // Filter entry addressing
    localparam logic [4:0] SUFFIX_MIN = 5'h01;
    localparam logic [4:0] SUFFIX_MAX = 5'h10;

    // Queue geometry and error codes
    localparam int WORD_W = 16;
    localparam int OUT_Q_DEPTH = 8;
    localparam int ERR_Q_DEPTH = 8;
    localparam logic [15:0] ERR_NONE_CODE = 16'h0000;
    localparam logic [15:0] ERR_UNDEFINED_HEADER = 16'h0071;
    localparam logic [15:0] ERR_SUFFIX_RANGE = 16'h0072;
    localparam logic [15:0] ERR_OVERFLOW_CODE = 16'h015e;

    // Reset values
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        filt_never = 2'h0,
        filt_rise = 2'h1,
        filt_fall = 2'h2,
        filt_both = 2'h3
    } filter_mode_type;

    localparam filter_mode_type FILTER_RESET = filt_rise;

    typedef enum logic [3:0] {
        op_cond_query = 4'h1,
        op_event_query = 4'h2,
        op_filter_set = 4'h3,
        op_filter_query = 4'h4,
        op_enable_set = 4'h5,
        op_enable_query = 4'h6,
        op_error_query = 4'h7,
        op_clear_status = 4'h8,
        op_device_clear = 4'h9
    } op_type;

    typedef struct packed {
        op_type op;
        logic [4:0] suffix;
        filter_mode_type mode;
        logic [15:0] data;
    } cmd_type;

    typedef struct packed {
        logic sweep_running;
        logic output_active;
        logic setpoint_changed;
        logic output_at_90;
        logic fan_stopped;
        logic internal_over_temp;
        logic amp_over_temp;
        logic power_supply_fault;
        logic feedback_error;
        logic oscillation_error;
        logic overload_detected;
    } fault_inputs_type;

endpackage

// ===== rtl/edge_filter_bank.sv
`timescale 1ns/1ps
`default_nettype none

module edge_filter_bank
    import status_event_pkg::*;
#(
    parameter int WIDTH = COND_W
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] cond,
    input wire filter_mode_type [WIDTH-1:0] modes,
    output logic [WIDTH-1:0] hits,
    output logic [WIDTH-1:0] never_mask
);

    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] nxt_prev;

    // Per-bit edge selection against the previous condition word
    always_comb
    begin
        nxt_prev = cond;
        hits = '0;
        never_mask = '0;
        for (int i = 0; i < WIDTH; i++)
        begin
            case (modes[i])
                filt_rise: hits[i] = cond[i] & ~prev_ff[i];
                filt_fall: hits[i] = ~cond[i] & prev_ff[i];
                filt_both: hits[i] = cond[i] ^ prev_ff[i];
                filt_never: never_mask[i] = 1'b1;
                default: hits[i] = 1'b0;
            endcase
        end
    end

    // Previous word starts at zero, matching the cleared condition word
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            prev_ff <= '0;
        end
        else
        begin
            prev_ff <= nxt_prev;
        end
    end

endmodule // edge_filter_bank

`default_nettype wire

// ===== rtl/status_queue.sv
`timescale 1ns/1ps
`default_nettype none

module status_queue
    import status_event_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = OUT_Q_DEPTH,
    parameter bit OVERWRITE_LAST = 1'b0,
    parameter logic [WIDTH-1:0] LAST_MARK = '0
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full,
    output logic dropped
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0] rd_ff;
    logic [PW-1:0] nxt_rd;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic dropped_ff;
    logic nxt_dropped;

    // Ring slot at a given distance from a pointer
    function automatic logic [PW-1:0] slot(input logic [PW-1:0] p, input int off);
        return PW'((int'(p) + off) % DEPTH);
    endfunction

    // Flush first, then pop, then push, so a push in a flush cycle survives
    always_comb
    begin
        nxt_mem = mem_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        nxt_dropped = 1'b0;
        if (flush)
        begin
            nxt_rd = '0;
            nxt_cnt = '0;
        end
        else if (pop && cnt_ff != '0)
        begin
            nxt_rd = slot(rd_ff, 1);
            nxt_cnt = cnt_ff - CW'(1);
        end
        if (push)
        begin
            if (nxt_cnt != CW'(DEPTH))
            begin
                nxt_mem[slot(nxt_rd, int'(nxt_cnt))] = push_data;
                nxt_cnt = nxt_cnt + CW'(1);
            end
            else
            begin
                nxt_dropped = 1'b1;
                if (OVERWRITE_LAST)
                begin
                    nxt_mem[slot(nxt_rd, DEPTH - 1)] = LAST_MARK;
                end
            end
        end
    end

    // Pointer state resets; storage needs no reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rd_ff <= '0;
            cnt_ff <= '0;
            dropped_ff <= 1'b0;
        end
        else
        begin
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            dropped_ff <= nxt_dropped;
        end
        mem_ff <= nxt_mem;
    end

    assign head = mem_ff[rd_ff];
    assign empty = (cnt_ff == '0);
    assign full = (cnt_ff == CW'(DEPTH));
    assign dropped = dropped_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_queue_count_up: assert property (
        (push && !full && !pop && !flush) |=> cnt_ff == $past(cnt_ff) + CW'(1))
        else $error("queue count did not grow on push");

    a_overflow_last_mark: assert property (
        (OVERWRITE_LAST && full && push && !pop && !flush)
        |=> mem_ff[slot(rd_ff, DEPTH - 1)] == LAST_MARK && full)
        else $error("overflow did not mark last entry");

endmodule // status_queue

`default_nettype wire

// ===== testbench/remote_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module remote_ctrl_model
    import status_event_pkg::*;
(
    input wire logic sys_clk,
    output logic cmd_valid,
    output cmd_type cmd,
    output logic ctrl_read,
    input wire logic out_valid,
    input wire logic [WORD_W-1:0] out_word
);
    // Quiet bus from time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
        ctrl_read = 1'b0;
    end

    // One command strobe, then the released lines carry junk
    task automatic send(input op_type op, input logic [4:0] sfx, input filter_mode_type m,
        input logic [15:0] d);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = '{op, sfx, m, d};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd = cmd_type'(~cmd);
        repeat (3) @(negedge sys_clk);
    endtask

    // Takes the head word, bounded wait for it to show
    task automatic fetch(output logic [15:0] w, output bit ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(negedge sys_clk);
            ok = (out_valid === 1'b1);
        end
        w = out_word;
        ctrl_read = ok;
        @(negedge sys_clk);
        ctrl_read = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule // remote_ctrl_model

`default_nettype wire

// ===== testbench/status_event_and_queues_test.sv
`timescale 1ns/1ps
`default_nettype none

module status_event_and_queues_test
    import status_event_pkg::*;
;
    localparam int QD = 4;
    logic sys_clk, rst_b, new_message, deadlock, resp_push, err_push;
    logic cmd_valid, ctrl_read, resp_ready, out_valid, out_lost, err_ready;
    logic [15:0] resp_word, err_code, out_word, exp_w;
    logic [7:0] status_bits;
    fault_inputs_type fault_in;
    cmd_type cmd;
    logic [15:0] oq[$];
    logic [15:0] eq[$];
    int bad_count, checks_done, k;
    int cmap[11] = '{0, 1, 3, 0, 5, 6, 7, 8, 10, 11, 12};

    status_event_and_queues #(.OUT_DEPTH(QD), .ERR_DEPTH(QD)) i_status_event_and_queues (
        .sys_clk(sys_clk), .rst_b(rst_b), .faults(fault_in), .cmd_valid(cmd_valid),
        .cmd(cmd), .new_message(new_message), .deadlock(deadlock), .resp_push(resp_push),
        .resp_word(resp_word), .resp_ready(resp_ready), .ctrl_read(ctrl_read),
        .out_word(out_word), .out_valid(out_valid), .out_lost(out_lost),
        .err_push(err_push), .err_code(err_code), .err_ready(err_ready),
        .status_bits(status_bits));

    remote_ctrl_model i_remote_ctrl_model (
        .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd), .ctrl_read(ctrl_read),
        .out_valid(out_valid), .out_word(out_word));

    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Query, queue the expected answer in the model, then read the head back
    task automatic ask(input op_type op, input logic [4:0] sfx, input logic [15:0] exp);
        logic [15:0] w;
        bit ok;
        i_remote_ctrl_model.send(op, sfx, filt_never, 16'h0000);
        oq.push_back(exp);
        i_remote_ctrl_model.fetch(w, ok);
        if (!ok)
        begin
            bad_count++;
            give_verdict();
        end
        check(w, oq.pop_front());
    endtask

    // Outside answer; the model drops it when full and expects a lost pulse
    task automatic push_resp(input logic [15:0] c);
        @(negedge sys_clk);
        resp_push = 1'b1;
        resp_word = c;
        check(16'(resp_ready), 16'h0001);
        @(negedge sys_clk);
        resp_push = 1'b0;
        resp_word = ~c;
        check(16'(out_lost), 16'(oq.size() >= QD));
        if (oq.size() < QD)
            oq.push_back(c);
    endtask

    // Error entry; overflow turns the last one into the overflow code
    task automatic add_err(input logic [15:0] c);
        if (eq.size() < QD)
            eq.push_back(c);
        else
            eq[QD-1] = 16'h015e;
    endtask

    task automatic push_err(input logic [15:0] c);
        @(negedge sys_clk);
        err_push = 1'b1;
        err_code = c;
        check(16'(err_ready), 16'h0001);
        @(negedge sys_clk);
        err_push = 1'b0;
        err_code = ~c;
        add_err(c);
    endtask

    // Flush strobe: new message or deadlock
    task automatic strobe(input bit dl);
        @(negedge sys_clk);
        new_message = !dl;
        deadlock = dl;
        @(negedge sys_clk);
        new_message = 1'b0;
        deadlock = 1'b0;
    endtask

    task automatic empty_check();
        repeat (3) @(negedge sys_clk);
        oq.delete();
        check(16'(out_valid), 16'h0000);
        check(16'(status_bits[SB_MSG_AVAIL]), 16'h0000);
    endtask

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        fault_in = '0;
        {new_message, deadlock, resp_push, err_push} = 4'h0;
        resp_word = 16'h0000;
        err_code = 16'h0000;
        bad_count = 0;
        checks_done = 0;
        void'($urandom(18));
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        check(16'(status_bits), 16'h0000);
        fault_in = '1;
        repeat (2) @(negedge sys_clk);
        ask(op_cond_query, 5'h00, 16'h1deb);
        for (k = 0; k < 11; k++)
        begin
            fault_in = fault_inputs_type'(11'h400 >> k);
            repeat (2) @(negedge sys_clk);
            // Settling bit holds from the all-ones step until the 90% flag at step 3
            exp_w = ((k < 3) ? 16'h0008 : 16'h0000) | ((k == 3) ? 16'h0000 : 16'h0001 << cmap[k]);
            ask(op_cond_query, 5'h00, exp_w);
        end
        fault_in = '0;
        for (k = 0; k < 4; k++)
        begin
            i_remote_ctrl_model.send(op_filter_set, 5'h02, filter_mode_type'(k), 16'h0000);
            ask(op_filter_query, 5'h02, 16'(k));
            i_remote_ctrl_model.send(op_clear_status, 5'h00, filt_never, 16'h0000);
            fault_in.output_active = 1'b1;
            repeat (2) @(negedge sys_clk);
            ask(op_event_query, 5'h00, (k % 2 == 1) ? 16'h0002 : 16'h0000);
            fault_in.output_active = 1'b0;
            repeat (2) @(negedge sys_clk);
            ask(op_event_query, 5'h00, (k >= 2) ? 16'h0002 : 16'h0000);
        end
        i_remote_ctrl_model.send(op_filter_set, 5'h10, filt_fall, 16'h0000);
        ask(op_filter_query, 5'h10, 16'h0002);
        i_remote_ctrl_model.send(op_enable_set, 5'h00, filt_never, 16'h0002);
        ask(op_enable_query, 5'h00, 16'h0002);
        // Sweep end latched through a falling filter on entry 1
        i_remote_ctrl_model.send(op_filter_set, 5'h01, filt_fall, 16'h0000);
        fault_in.sweep_running = 1'b1;
        repeat (2) @(negedge sys_clk);
        fault_in.sweep_running = 1'b0;
        repeat (2) @(negedge sys_clk);
        fault_in.output_active = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(16'(status_bits[SB_EXT_SUMMARY]), 16'h0001);
        ask(op_event_query, 5'h00, 16'h0003);
        check(16'(status_bits[SB_EXT_SUMMARY]), 16'h0000);
        // Output queue: overfill, order, flush causes
        for (k = 0; k <= QD; k++)
            push_resp(16'($urandom));
        check(16'(status_bits[SB_MSG_AVAIL]), 16'h0001);
        i_remote_ctrl_model.send(op_clear_status, 5'h00, filt_never, 16'h0000);
        ask(op_cond_query, 5'h00, oq[0]);
        strobe(1'b0);
        empty_check();
        push_resp(16'($urandom));
        strobe(1'b1);
        empty_check();
        push_resp(16'($urandom));
        i_remote_ctrl_model.send(op_device_clear, 5'h00, filt_never, 16'h0000);
        empty_check();
        // Error queue: codes, overflow, order, clearing
        push_err(16'($urandom));
        i_remote_ctrl_model.send(op_type'(4'h0), 5'h00, filt_never, 16'h0000);
        add_err(16'h0071);
        i_remote_ctrl_model.send(op_filter_set, 5'h00, filt_both, 16'h0000);
        add_err(16'h0072);
        push_err(16'($urandom));
        push_err(16'($urandom));
        check(16'(status_bits[SB_ERROR_AVAIL]), 16'h0001);
        for (k = 0; k < QD; k++)
            ask(op_error_query, 5'h00, eq.pop_front());
        push_err(16'($urandom));
        strobe(1'b0);
        ask(op_error_query, 5'h00, eq.pop_front());
        push_err(16'($urandom));
        i_remote_ctrl_model.send(op_clear_status, 5'h00, filt_never, 16'h0000);
        eq.delete();
        check(16'(status_bits[SB_ERROR_AVAIL]), 16'h0000);
        ask(op_error_query, 5'h00, 16'h0000);
        // Restart empties both queues
        push_resp(16'($urandom));
        push_err(16'($urandom));
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(16'(status_bits), 16'h0000);
        give_verdict();
    end
endmodule // status_event_and_queues_test

`default_nettype wire
